// ### usbat_params.svh
`ifndef USBAT_PARAMS_SVH
`define USBAT_PARAMS_SVH
// general purpose pin bank
`define USBAT_GP_PINS 16
`define USBAT_GP_SEL_W 4
// max power setting in 2 mA units, as a usb power descriptor carries it
`define USBAT_MAXPWR_W 8
`define USBAT_MAXPWR_DEF 8'h96
`define USBAT_MAXPWR_UNCFG 8'h32
`define USBAT_MAXPWR_CFG 8'hfa
// default pin choices
`define USBAT_PULLUP_PIN_DEF 4'h0
`define USBAT_VBUS_PIN_DEF 4'h1
`define USBAT_DISC_PIN_DEF 4'h2
`define USBAT_WAKE_PIN_DEF 4'h3
`endif

// ### usbat_pkg.sv
`include "usbat_params.svh"
package usbat_pkg;
   typedef logic [`USBAT_GP_PINS-1:0] usbat_pins_t;
   typedef logic [`USBAT_GP_SEL_W-1:0] usbat_sel_t;
   typedef logic [`USBAT_MAXPWR_W-1:0] usbat_pwr_t;
   typedef enum logic [1:0] {
      USBAT_DETACHED = 2'b00,
      USBAT_ATTACHED = 2'b01,
      USBAT_CONFIGURED = 2'b10,
      USBAT_SUSPENDED = 2'b11
   } usbat_state_t;
endpackage

// ### usbat_sync.sv
`timescale 1ns/1ps
// three stage synchroniser for one pin; a change counts once the last two stages agree
module usbat_sync (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   input wire logic pin_in,
   output logic level_out
);
   logic s1_r;
   logic s2_r;
   logic s3_r;
   // s1 feeds only s2 to keep metastability contained
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         level_out <= 1'b0;
      end else if (ce_in) begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level_out <= s3_r;
         end
      end
   end
endmodule

// ### usbat_top.sv
`timescale 1ns/1ps
`include "usbat_params.svh"
module usbat_top (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   input wire logic [`USBAT_GP_PINS-1:0] gp_pins_in,
   input wire logic ext_pullup_sel_in,
   input wire logic self_powered_in,
   input wire logic audio_endpoints_in,
   input wire usbat_pkg::usbat_sel_t pullup_pin_select_in,
   input wire usbat_pkg::usbat_sel_t vbus_pin_select_in,
   input wire usbat_pkg::usbat_sel_t disconnect_pin_select_in,
   input wire usbat_pkg::usbat_sel_t wake_pin_select_in,
   input wire usbat_pkg::usbat_pwr_t max_power_setting_in,
   input wire logic max_power_load_in,
   input wire logic ready_in,
   input wire logic configured_in,
   input wire logic bus_suspend_in,
   input wire logic wake_req_in,
   input wire logic host_req_in,
   input wire logic resp_in,
   output logic int_pullup_en_out,
   output logic [`USBAT_GP_PINS-1:0] gp_pins_out,
   output logic [`USBAT_GP_PINS-1:0] gp_pins_oe_n_out,
   output logic data_hiz_out,
   output logic resp_out,
   output logic audio_endpoints_out,
   output logic full_speed_out,
   output usbat_pkg::usbat_pwr_t power_desc_out,
   output usbat_pkg::usbat_pwr_t power_limit_out,
   output logic radio_off_out,
   output logic loads_off_out,
   output logic remote_wake_out,
   output logic [1:0] state_out
);
   import usbat_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers, one per gp pin
   wire [`USBAT_GP_PINS-1:0] pins_sync;
   genvar gi;
   generate
      for (gi = 0; gi < `USBAT_GP_PINS; gi = gi + 1) begin : g_sync
         usbat_sync u_sync (
            .clk_in(clk_in),
            .reset_in(reset_in),
            .ce_in(ce_in),
            .pin_in(gp_pins_in[gi]),
            .level_out(pins_sync[gi])
         );
      end
   endgenerate

   // attach state, declared ahead of the decode that reads it
   usbat_state_t state_r;
   usbat_state_t state_nxt;

   ////////////////////////////////////////////////////////////////////
   // decoding of mapped pins
   wire vbus_sensed = pins_sync[vbus_pin_select_in];
   wire detach = pins_sync[disconnect_pin_select_in];
   // bus powered parts always see vbus; self powered must sense it
   wire vbus_ok = !self_powered_in || vbus_sensed;
   wire attach_ok = ready_in && vbus_ok && !detach;
   wire pullup_on = attach_ok && (state_r != USBAT_DETACHED);
   wire use_ext = ext_pullup_sel_in;
   wire wake_on = detach && wake_req_in;
   wire susp_bp = (state_r == USBAT_SUSPENDED) && !self_powered_in;

   ////////////////////////////////////////////////////////////////////
   // attach state transitions
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         USBAT_DETACHED: begin
            if (attach_ok) begin
               state_nxt = USBAT_ATTACHED;
            end
         end
         USBAT_ATTACHED: begin
            if (!attach_ok) begin
               state_nxt = USBAT_DETACHED;
            end else if (bus_suspend_in) begin
               state_nxt = USBAT_SUSPENDED;
            end else if (configured_in) begin
               state_nxt = USBAT_CONFIGURED;
            end
         end
         USBAT_CONFIGURED: begin
            if (!attach_ok) begin
               state_nxt = USBAT_DETACHED;
            end else if (bus_suspend_in) begin
               state_nxt = USBAT_SUSPENDED;
            end else if (!configured_in) begin
               state_nxt = USBAT_ATTACHED;
            end
         end
         USBAT_SUSPENDED: begin
            if (!attach_ok) begin
               state_nxt = USBAT_DETACHED;
            end else if (!bus_suspend_in) begin
               state_nxt = configured_in ? USBAT_CONFIGURED : USBAT_ATTACHED;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_r <= USBAT_DETACHED;
      end else if (ce_in) begin
         state_r <= state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pull-up and pin drive; oe low means driving
   usbat_pins_t pins_nxt;
   usbat_pins_t oe_n_nxt;
   always_comb begin
      pins_nxt = '0;
      oe_n_nxt = '1;
      if (use_ext) begin
         pins_nxt[pullup_pin_select_in] = pullup_on;
         oe_n_nxt[pullup_pin_select_in] = !pullup_on;
      end
      pins_nxt[wake_pin_select_in] = wake_on;
      oe_n_nxt[wake_pin_select_in] = 1'b0;
   end

   // usb power ceiling for the state, sent out as the limit; descriptor power is not clamped to it
   wire [`USBAT_MAXPWR_W-1:0] lim =
      (state_r == USBAT_CONFIGURED) ? `USBAT_MAXPWR_CFG : `USBAT_MAXPWR_UNCFG;

   usbat_pwr_t maxpwr_r;
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         maxpwr_r <= `USBAT_MAXPWR_DEF;
      end else if (ce_in && max_power_load_in) begin
         maxpwr_r <= max_power_setting_in;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         int_pullup_en_out <= 1'b0;
         gp_pins_out <= '0;
         gp_pins_oe_n_out <= '1;
         data_hiz_out <= 1'b1;
         resp_out <= 1'b0;
         audio_endpoints_out <= 1'b0;
         full_speed_out <= 1'b0;
         power_desc_out <= `USBAT_MAXPWR_DEF;
         power_limit_out <= `USBAT_MAXPWR_UNCFG;
         radio_off_out <= 1'b0;
         loads_off_out <= 1'b0;
         remote_wake_out <= 1'b0;
         state_out <= 2'b00;
      end else if (ce_in) begin
         int_pullup_en_out <= pullup_on && !use_ext;
         gp_pins_out <= pins_nxt;
         gp_pins_oe_n_out <= oe_n_nxt;
         data_hiz_out <= detach || (state_r == USBAT_DETACHED);
         // answers only to host requests, never originates traffic
         resp_out <= resp_in && host_req_in && pullup_on;
         audio_endpoints_out <= audio_endpoints_in;
         full_speed_out <= pullup_on;
         power_desc_out <= maxpwr_r;
         power_limit_out <= lim;
         radio_off_out <= susp_bp;
         loads_off_out <= susp_bp;
         // in-band wake only while attached and suspended
         remote_wake_out <= wake_req_in && !detach &&
            (state_r == USBAT_SUSPENDED);
         state_out <= state_r;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   a_pullup_needs_vbus: assert property (@(posedge clk_in)
      disable iff (reset_in) (self_powered_in && !vbus_sensed && ce_in)
      |=> !int_pullup_en_out && !full_speed_out)
      else $error("pull-up on without vbus");
   a_detach_hiz: assert property (@(posedge clk_in)
      disable iff (reset_in) (detach && ce_in) |=> data_hiz_out &&
      !int_pullup_en_out)
      else $error("detached but lines driven");
   a_no_inband_wake: assert property (@(posedge clk_in)
      disable iff (reset_in) remote_wake_out |-> !$past(detach))
      else $error("in-band wake while detached");
   a_suspend_radio: assert property (@(posedge clk_in)
      disable iff (reset_in) (ce_in && susp_bp) |=> radio_off_out)
      else $error("radio on in bus-powered suspend");
   a_power_limit: assert property (@(posedge clk_in)
      disable iff (reset_in) (ce_in && state_r != USBAT_CONFIGURED)
      |=> power_limit_out == `USBAT_MAXPWR_UNCFG)
      else $error("unconfigured limit wrong");
   a_reattach: assert property (@(posedge clk_in)
      disable iff (reset_in) (ce_in && state_r == USBAT_DETACHED &&
      attach_ok) |=> state_r == USBAT_ATTACHED)
      else $error("no reattach");
   // outputs hold while ce is low, so only a freshly loaded value counts
   a_resp_only: assert property (@(posedge clk_in)
      disable iff (reset_in) ($past(ce_in) && resp_out)
      |-> $past(host_req_in))
      else $error("unsolicited response");
   a_pullup_ready: assert property (@(posedge clk_in)
      disable iff (reset_in) ($past(ce_in) && int_pullup_en_out)
      |-> $past(ready_in))
      else $error("pull-up before ready");
endmodule

// ### usbat_host_model.sv
`timescale 1ns/1ps
// host side stand-in: drives the detach and vbus sense pins, watches wake
module usbat_host_model (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic detach_req_in,
   input wire logic vbus_on_in,
   input wire logic wake_in,
   output logic detach_out,
   output logic vbus_out
);
   logic req_q_r;
   // sense divider passes vbus straight through as a pin level
   assign vbus_out = vbus_on_in;
   // detach is raised on a request edge only, so a held request cannot
   // fight the release that follows a wake
   always_ff @(posedge clk_in) begin
      req_q_r <= detach_req_in;
      if (reset_in) begin
         detach_out <= 1'b0;
      end else if (wake_in && detach_out) begin
         detach_out <= 1'b0;
      end else if (detach_req_in && !req_q_r) begin
         detach_out <= 1'b1;
      end
   end
endmodule

// ### tb_usbat_top.sv
`timescale 1ns/1ps
`include "usbat_params.svh"
`define CHK(a, e) check_count++; if ((a) !== (e)) begin num_errors++; \
   $display("mismatch at %0t: got %h want %h", $time, a, e); end
module tb_usbat_top;
   import usbat_pkg::*;
   typedef struct packed {
      logic rdy, sp, vb, ext, cfg, sus;
      logic [1:0] st;
      logic pu, ep, hz, ro;
      logic [7:0] lim;
   } usbat_row_t;
   logic clk_in = 0, reset_in = 1, ext = 0, sp = 0, aud = 0, ld = 0;
   logic rdy = 0, cfg = 0, sus = 0, wreq = 0, hreq = 0, det_req = 0;
   logic ce = 1;
   logic vb_on = 0, det, vbus, pu, hz, rsp, audo, fs, ro, lo, rw, wake;
   logic [15:0] gin, gout, goe_n;
   usbat_pwr_t pset = 8'h00, pdesc, plim;
   logic [1:0] st;
   int num_errors = 0, check_count = 0;
   usbat_row_t rows[8] = '{
      {6'b000000, 2'h0, 4'b0010, 8'h32}, {6'b100000, 2'h1, 4'b1000, 8'h32},
      {6'b100100, 2'h1, 4'b0100, 8'h32}, {6'b110000, 2'h0, 4'b0010, 8'h32},
      {6'b111100, 2'h1, 4'b0100, 8'h32}, {6'b101010, 2'h2, 4'b1000, 8'hfa},
      {6'b101011, 2'h3, 4'b1001, 8'h32}, {6'b111111, 2'h3, 4'b0100, 8'h32}};
   // pin bank as the board wires it: vbus sense on 5, detach on 9
   always_comb begin
      gin = 16'h0000;
      gin[5] = vbus;
      gin[9] = det;
   end
   assign wake = gout[12] & ~goe_n[12];
   initial begin
      forever #2.5 clk_in = ~clk_in;
   end
   usbat_host_model host (.clk_in(clk_in), .reset_in(reset_in),
      .detach_req_in(det_req), .vbus_on_in(vb_on), .wake_in(wake),
      .detach_out(det), .vbus_out(vbus));
   usbat_top dut (.clk_in(clk_in), .reset_in(reset_in), .ce_in(ce),
      .gp_pins_in(gin), .ext_pullup_sel_in(ext), .self_powered_in(sp),
      .audio_endpoints_in(aud), .pullup_pin_select_in(4'h6),
      .vbus_pin_select_in(4'h5), .disconnect_pin_select_in(4'h9),
      .wake_pin_select_in(4'hc), .max_power_setting_in(pset),
      .max_power_load_in(ld), .ready_in(rdy), .configured_in(cfg),
      .bus_suspend_in(sus), .wake_req_in(wreq), .host_req_in(hreq),
      .resp_in(1'b1), .int_pullup_en_out(pu), .gp_pins_out(gout),
      .gp_pins_oe_n_out(goe_n), .data_hiz_out(hz), .resp_out(rsp),
      .audio_endpoints_out(audo), .full_speed_out(fs),
      .power_desc_out(pdesc), .power_limit_out(plim), .radio_off_out(ro),
      .loads_off_out(lo), .remote_wake_out(rw), .state_out(st));
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // bounded wait on the state, then two edges for outputs to follow it
   task automatic settle(input logic [1:0] want);
      int n;
      n = 0;
      while (st !== want && n < 20) begin
         @(negedge clk_in);
         n++;
      end
      if (n == 20) begin
         num_errors++;
         $display("mismatch at %0t: state wait ran out", $time);
         test_done();
      end
      repeat (2) @(negedge clk_in);
   endtask
   initial begin
      int n;
      repeat (2) @(negedge clk_in);
      `CHK({pu, hz, goe_n}, {2'b01, 16'hffff})
      `CHK({pdesc, plim}, {`USBAT_MAXPWR_DEF, `USBAT_MAXPWR_UNCFG})
      reset_in = 0;
      $display("reset test done");
      // table pass: attach, pull-up choice, vbus sense, config, suspend
      foreach (rows[i]) begin
         {rdy, sp, vb_on, ext, cfg, sus} = rows[i][19:14];
         settle(rows[i].st);
         `CHK({pu, gout[6], hz, ro}, rows[i][11:8])
         `CHK(lo, rows[i].ro)
         `CHK(plim, rows[i].lim)
         `CHK(fs, rows[i].st != 2'h0)
      end
      $display("table test done");
      {sp, vb_on, ext, cfg, sus, aud, hreq, wreq} = 8'h07;
      pset = 8'h64;
      ld = 1;
      @(negedge clk_in);
      ld = 0;
      settle(2'h1);
      `CHK({audo, rsp, pdesc}, {2'b11, 8'h64})
      `CHK(wake, 1'b0)
      wreq = 0;
      det_req = 1;
      settle(2'h0);
      `CHK({pu, hz, rsp, goe_n[9]}, 4'b0101)
      wreq = 1;
      n = 0;
      while (!wake && n < 20) begin
         @(negedge clk_in);
         n++;
      end
      `CHK(wake, 1'b1)
      `CHK(rw, 1'b0)
      settle(2'h1);
      `CHK({det, pu, hz}, 3'b010)
      $display("detach test done");
      // attached and suspended: in-band wake is allowed again
      sus = 1;
      settle(2'h3);
      `CHK(rw, 1'b1)
      // ce low freezes everything, even a dropped ready
      ce = 0;
      rdy = 0;
      repeat (4) @(negedge clk_in);
      `CHK({st, pu, rw}, 4'b1111)
      ce = 1;
      settle(2'h0);
      `CHK({pu, fs, hz, rw}, 4'b0010)
      $display("clock enable test done");
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      num_errors++;
      test_done();
   end
endmodule
